//--- timer1_control.v
`timescale 1ns/1ps
`include "timer_map.vh"
// Behaviour
// - Clear-on-top set: counter returns to zero the cycle after top match.
// - Channel A PWM enable selects PWM and clears counter after top match.
// - Normal mode channel A match: disconnect, toggle, clear or set pin.
// - Normal mode channel B match: same encoding on channel B pin.
// - True compare outputs reach a pin only when its direction bit is output; inverted outputs ignore it.
// - Normal mode keeps inverted outputs disconnected.
// - Clock select 0 stops; 1 undivided; up to divide by 16384.
// - Prescaler source: fast clock asynchronous, system clock synchronous.
// - Channel B PWM enable selects PWM and clears counter after top match.
// - Force B applies channel B action as a match, no interrupt.
// - Force A applies channel A action as a match, no interrupt.
// - Force written with new mode bits uses the new mode bits.
// - Force strobes read zero and are ignored while that PWM is on.
// - Prescaler reset clears prescaler only, self-clears, reads zero.
// - Counter is an 8-bit up counter, readable and writable.
// - Counter write lands after two cycles sync, one cycle async.
// - PWM mode output table for true and inverted outputs.
// - PWM mode counts zero to top, then restarts at zero.
module timer1_control (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Fast peripheral clock tick, already in clk_sys domain
    input  wire        fast_clk_tick,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Compare output pins
    output reg         compare_out_a,
    output reg         compare_out_a_oe,
    output reg         compare_out_a_n,
    output reg         compare_out_a_n_oe,
    output reg         compare_out_b,
    output reg         compare_out_b_oe,
    output reg         compare_out_b_n,
    output reg         compare_out_b_n_oe
);
    //------------------------------------------------------------
    // Register state
    //------------------------------------------------------------
    reg  [7:0]  general_ctrl_reg;
    reg  [7:0]  timer_ctrl_reg;
    reg  [7:0]  counter_reg;
    reg  [7:0]  compare_a_reg;
    reg  [7:0]  compare_b_reg;
    reg  [7:0]  top_reg;
    reg  [2:0]  pin_cfg_reg;
    reg         out_a_reg;
    reg         out_b_reg;
    reg         aw_hold_reg;
    reg         w_hold_reg;
    reg  [7:0]  awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    reg  [7:0]  cnt_wdata_reg;
    reg         cnt_wr_stage1_reg;
    reg         cnt_wr_stage2_reg;
    reg         force_a_reg;
    reg         force_b_reg;
    reg         psr_pulse_reg;
    reg  [7:0]  prev_cnt_reg;

    wire        tick;
    wire        pwm_a = timer_ctrl_reg[`TC_PWM_A];
    wire        pwm_b = general_ctrl_reg[`GC_PWM_B];
    wire [1:0]  mode_a = timer_ctrl_reg[`TC_MODE_A_HI:`TC_MODE_A_LO];
    wire [1:0]  mode_b = general_ctrl_reg[`GC_MODE_B_HI:`GC_MODE_B_LO];
    wire        async_mode = pin_cfg_reg[`PC_FAST_CLK_EN];
    wire        wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    wire        wr_lane0 = wstrb_reg[0];

    //------------------------------------------------------------
    // Helper functions
    //------------------------------------------------------------
    // Normal mode action on a match
    function normal_action;
        input [1:0] mode;
        input       cur;
        begin
            case (mode)
                `MODE_TOGGLE: normal_action = ~cur;
                `MODE_CLEAR:  normal_action = 1'b0;
                `MODE_SET:    normal_action = 1'b1;
                default:      normal_action = cur;
            endcase
        end
    endfunction

    // PWM action: match and bottom events
    function pwm_action;
        input [1:0] mode;
        input       cur;
        input       match;
        input       bottom;
        begin
            if (mode == `MODE_SET)
                pwm_action = match ? 1'b1 : (bottom ? 1'b0 : cur);
            else if (mode != `MODE_OFF)
                pwm_action = match ? 1'b0 : (bottom ? 1'b1 : cur);
            else
                pwm_action = cur;
        end
    endfunction

    // Read mux
    function [7:0] read_mux;
        input [7:0] addr;
        input [7:0] gen;
        input [7:0] tcr;
        input [7:0] cnt;
        input [7:0] ca;
        input [7:0] cb;
        input [7:0] top;
        input [2:0] pc;
        begin
            case (addr)
                `OFS_GENERAL_CTRL: read_mux = gen & 8'hF1;
                `OFS_TIMER_CTRL:   read_mux = tcr;
                `OFS_COUNTER:      read_mux = cnt;
                `OFS_COMPARE_A:    read_mux = ca;
                `OFS_COMPARE_B:    read_mux = cb;
                `OFS_TOP_COMPARE:  read_mux = top;
                `OFS_PIN_CONFIG:   read_mux = {5'h00, pc};
                default:           read_mux = 8'h00;
            endcase
        end
    endfunction

    function addr_ok;
        input [7:0] addr;
        begin
            addr_ok = (addr == `OFS_GENERAL_CTRL) || (addr == `OFS_TIMER_CTRL) ||
                      (addr == `OFS_COUNTER) || (addr == `OFS_COMPARE_A) ||
                      (addr == `OFS_COMPARE_B) || (addr == `OFS_TOP_COMPARE) ||
                      (addr == `OFS_PIN_CONFIG);
        end
    endfunction

    //------------------------------------------------------------
    // Prescaler
    //------------------------------------------------------------
    timer_prescaler u_prescaler (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .src_tick     (async_mode ? fast_clk_tick : 1'b1),
        .clear        (psr_pulse_reg),
        .clock_select (timer_ctrl_reg[3:0]),
        .tick         (tick)
    );

    //------------------------------------------------------------
    // AXI4-Lite write channel
    //------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h00000000;
            wstrb_reg     <= 4'h0;
        end else begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_ok(awaddr_reg) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // AXI4-Lite read channel
    //------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, read_mux(s_axi_araddr, general_ctrl_reg,
                                 timer_ctrl_reg, counter_reg, compare_a_reg,
                                 compare_b_reg, top_reg, pin_cfg_reg)};
                s_axi_rresp  <= addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // Control registers and strobes
    //------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            general_ctrl_reg  <= `RST_GENERAL_CTRL;
            timer_ctrl_reg    <= `RST_TIMER_CTRL;
            compare_a_reg     <= 8'h00;
            compare_b_reg     <= 8'h00;
            top_reg           <= `RST_TOP_COMPARE;
            pin_cfg_reg       <= 3'h0;
            force_a_reg       <= 1'b0;
            force_b_reg       <= 1'b0;
            psr_pulse_reg     <= 1'b0;
            cnt_wr_stage1_reg <= 1'b0;
            cnt_wdata_reg     <= 8'h00;
        end else begin
            force_a_reg       <= 1'b0;
            force_b_reg       <= 1'b0;
            psr_pulse_reg     <= 1'b0;
            cnt_wr_stage1_reg <= 1'b0;
            if (wr_fire && wr_lane0) begin
                case (awaddr_reg)
                    `OFS_GENERAL_CTRL: begin
                        // Strobe bits are not stored; others kept
                        general_ctrl_reg <= wdata_reg[7:0] & 8'hF1;
                        force_a_reg   <= wdata_reg[`GC_FORCE_A];
                        force_b_reg   <= wdata_reg[`GC_FORCE_B];
                        psr_pulse_reg <= wdata_reg[`GC_PRESCALER_RST];
                    end
                    `OFS_TIMER_CTRL:  timer_ctrl_reg <= wdata_reg[7:0];
                    `OFS_COUNTER: begin
                        cnt_wdata_reg     <= wdata_reg[7:0];
                        cnt_wr_stage1_reg <= 1'b1;
                    end
                    `OFS_COMPARE_A:   compare_a_reg <= wdata_reg[7:0];
                    `OFS_COMPARE_B:   compare_b_reg <= wdata_reg[7:0];
                    `OFS_TOP_COMPARE: top_reg <= wdata_reg[7:0];
                    `OFS_PIN_CONFIG:  pin_cfg_reg <= wdata_reg[2:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    //------------------------------------------------------------
    // Counter
    //------------------------------------------------------------
    // Tick at top in a clearing mode gives zero, so a period is top plus one
    // ticks; only a landing counter write drops a tick, so normal mode still counts through
    wire at_top_clear = tick && (counter_reg == top_reg) &&
                        (timer_ctrl_reg[`TC_CLEAR_TOP] || pwm_a || pwm_b);

    always @(posedge clk_sys) begin
        if (rst) begin
            counter_reg       <= 8'h00;
            prev_cnt_reg      <= 8'h00;
            cnt_wr_stage2_reg <= 1'b0;
        end else begin
            // Sync write lands two edges on; async one edge
            cnt_wr_stage2_reg <= cnt_wr_stage1_reg && !async_mode;
            prev_cnt_reg      <= counter_reg;
            if ((cnt_wr_stage1_reg && async_mode) || cnt_wr_stage2_reg)
                counter_reg <= cnt_wdata_reg;
            else if (at_top_clear)
                counter_reg <= 8'h00;
            else if (tick)
                counter_reg <= counter_reg + 8'h01;
        end
    end

    //------------------------------------------------------------
    // Compare outputs
    //------------------------------------------------------------
    wire match_a = (counter_reg == compare_a_reg) && (counter_reg != prev_cnt_reg);
    wire match_b = (counter_reg == compare_b_reg) && (counter_reg != prev_cnt_reg);
    wire bottom  = (counter_reg == 8'h00) && (prev_cnt_reg != 8'h00);
    // Force uses the mode bits already latched with it
    wire [1:0] eff_mode_a = mode_a;
    wire [1:0] eff_mode_b = mode_b;

    always @(posedge clk_sys) begin
        if (rst) begin
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
        end else begin
            if (pwm_a)
                out_a_reg <= pwm_action(eff_mode_a, out_a_reg, match_a, bottom);
            else if (match_a || force_a_reg)
                out_a_reg <= normal_action(eff_mode_a, out_a_reg);
            if (pwm_b)
                out_b_reg <= pwm_action(eff_mode_b, out_b_reg, match_b, bottom);
            else if (match_b || force_b_reg)
                out_b_reg <= normal_action(eff_mode_b, out_b_reg);
        end
    end

    // Pin drive with direction gating and inverted output handling
    always @(posedge clk_sys) begin
        if (rst) begin
            compare_out_a      <= 1'b0;
            compare_out_a_oe   <= 1'b0;
            compare_out_a_n    <= 1'b0;
            compare_out_a_n_oe <= 1'b0;
            compare_out_b      <= 1'b0;
            compare_out_b_oe   <= 1'b0;
            compare_out_b_n    <= 1'b0;
            compare_out_b_n_oe <= 1'b0;
        end else begin
            compare_out_a      <= out_a_reg;
            compare_out_b      <= out_b_reg;
            compare_out_a_n    <= ~out_a_reg;
            compare_out_b_n    <= ~out_b_reg;
            compare_out_a_oe   <= pin_cfg_reg[`PC_DIR_A] && (mode_a != `MODE_OFF);
            compare_out_b_oe   <= pin_cfg_reg[`PC_DIR_B] && (mode_b != `MODE_OFF);
            compare_out_a_n_oe <= pwm_a && (mode_a == `MODE_TOGGLE);
            compare_out_b_n_oe <= pwm_b && (mode_b == `MODE_TOGGLE);
        end
    end
endmodule // timer1_control

//--- timer_map.vh
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
// Register byte offsets
`define OFS_GENERAL_CTRL   8'h2C
`define OFS_TIMER_CTRL     8'h30
`define OFS_COUNTER        8'h34
`define OFS_COMPARE_A      8'h38
`define OFS_COMPARE_B      8'h3C
`define OFS_TOP_COMPARE    8'h40
`define OFS_PIN_CONFIG     8'h44
// Timer control fields
`define TC_CLEAR_TOP       7
`define TC_PWM_A           6
`define TC_MODE_A_HI       5
`define TC_MODE_A_LO       4
// General control fields
`define GC_SYNC_MODE       7
`define GC_PWM_B           6
`define GC_MODE_B_HI       5
`define GC_MODE_B_LO       4
`define GC_FORCE_B         3
`define GC_FORCE_A         2
`define GC_PRESCALER_RST   1
`define GC_OTHER_PSR       0
// Pin configuration fields
`define PC_DIR_A           0
`define PC_DIR_B           1
`define PC_FAST_CLK_EN     2
// Reset values
`define RST_GENERAL_CTRL   8'h00
`define RST_TIMER_CTRL     8'h00
`define RST_TOP_COMPARE    8'hFF
// Output mode codes
`define MODE_OFF           2'h0
`define MODE_TOGGLE        2'h1
`define MODE_CLEAR         2'h2
`define MODE_SET           2'h3
`endif

//--- timer_prescaler.v
`timescale 1ns/1ps
// Prescaler: 14-bit divider chain producing one tick per selected period
module timer_prescaler (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst,
    // Control
    input  wire       src_tick,
    input  wire       clear,
    input  wire [3:0] clock_select,
    // Tick out
    output reg        tick
);
    reg [13:0] div_reg;
    reg [13:0] div_next;
    reg [13:0] mask;

    // Divider and tick selection: tick when low bits all one
    always @* begin
        div_next = src_tick ? div_reg + 14'h0001 : div_reg;
        mask     = (14'h0001 << (clock_select - 4'h1)) - 14'h0001;
    end

    always @(posedge clk_sys) begin
        if (rst || clear) begin
            div_reg <= 14'h0000;
            tick    <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick    <= src_tick && (clock_select != 4'h0) &&
                       ((div_reg & mask) == mask);
        end
    end
endmodule // timer_prescaler

//--- timer1_control_monitor.sv
`timescale 1ns/1ps
`include "timer_map.vh"
module timer1_control_monitor (
    // Clock and reset
    input wire        clk_sys,
    input wire        rst,
    // Register bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    // Compare pins
    input wire        compare_out_a,
    input wire        compare_out_a_oe,
    input wire        compare_out_a_n,
    input wire        compare_out_a_n_oe,
    input wire        compare_out_b,
    input wire        compare_out_b_oe,
    input wire        compare_out_b_n,
    input wire        compare_out_b_n_oe
);
    // ------------------------------------------------------------
    // Read address decode
    // ------------------------------------------------------------
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire ar_map  = s_axi_araddr == `OFS_GENERAL_CTRL || s_axi_araddr == `OFS_TIMER_CTRL
                || s_axi_araddr == `OFS_COUNTER || s_axi_araddr == `OFS_COMPARE_A
                || s_axi_araddr == `OFS_COMPARE_B || s_axi_araddr == `OFS_TOP_COMPARE
                || s_axi_araddr == `OFS_PIN_CONFIG;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Bus and pin properties
    // ------------------------------------------------------------
    a_rvalid_cause: assert property ($rose(s_axi_rvalid) |-> $past(ar_take))
        else $error("read data without a read address");
    a_unmapped_read: assert property (ar_take && !ar_map
        |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_read: assert property (ar_take && ar_map
        |=> s_axi_rvalid && s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0)
        else $error("mapped read answer wrong");
    a_strobe_reads: assert property (ar_take && s_axi_araddr == `OFS_GENERAL_CTRL
        |=> s_axi_rdata[3:1] == 3'h0) else $error("strobe bits read nonzero");
    a_inv_a_pair: assert property (compare_out_a_n_oe |-> compare_out_a_n != compare_out_a)
        else $error("channel a inverted output not complementary");
    a_inv_b_pair: assert property (compare_out_b_n_oe |-> compare_out_b_n != compare_out_b)
        else $error("channel b inverted output not complementary");
    a_reset_quiet: assert property ($fell(rst) |-> !(compare_out_a_oe || compare_out_b_oe
        || compare_out_a_n_oe || compare_out_b_n_oe)) else $error("pins driven after reset");
    a_aw_answer: assert property (s_axi_awvalid && !s_axi_awready |-> ##[1:4] s_axi_awready)
        else $error("write address not accepted in time");
    a_ar_answer: assert property (s_axi_arvalid && !s_axi_arready |-> ##[1:4] s_axi_arready)
        else $error("read address not accepted in time");
endmodule // timer1_control_monitor

bind timer1_control timer1_control_monitor u_timer1_control_monitor (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .compare_out_a(compare_out_a), .compare_out_a_oe(compare_out_a_oe),
    .compare_out_a_n(compare_out_a_n), .compare_out_a_n_oe(compare_out_a_n_oe),
    .compare_out_b(compare_out_b), .compare_out_b_oe(compare_out_b_oe),
    .compare_out_b_n(compare_out_b_n), .compare_out_b_n_oe(compare_out_b_n_oe));

//--- timer1_control_bench.sv
`timescale 1ns/1ps
`include "timer_map.vh"
module timer1_control_bench;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk_sys = 1'h0, rst = 1'h1, fast_clk_tick = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire         compare_out_a, compare_out_a_oe, compare_out_a_n, compare_out_a_n_oe;
    wire         compare_out_b, compare_out_b_oe, compare_out_b_n, compare_out_b_n_oe;
    int          error_cnt = 0, n_checks = 0, cyc = 0, i, t0, hi;
    logic [31:0] rd_val;
    logic [1:0]  rd_resp, wr_resp, m;
    logic [7:0]  v0;
    logic [1:0]  mtab [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
    logic        vtab [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};

    timer1_control u_timer1_control (
        .clk_sys(clk_sys), .rst(rst), .fast_clk_tick(fast_clk_tick),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .compare_out_a(compare_out_a), .compare_out_a_oe(compare_out_a_oe),
        .compare_out_a_n(compare_out_a_n), .compare_out_a_n_oe(compare_out_a_n_oe),
        .compare_out_b(compare_out_b), .compare_out_b_oe(compare_out_b_oe),
        .compare_out_b_n(compare_out_b_n), .compare_out_b_n_oe(compare_out_b_n_oe));

    // Clock, cycle count and a fast tick on every other cycle
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        fast_clk_tick <= ~fast_clk_tick;
    end

    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd_val = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // Counter advance over exactly 64 clock cycles
    task automatic rate(input string nm, input logic [7:0] tcr, input logic [7:0] exp);
        wr(`OFS_TIMER_CTRL, {24'h0, tcr});
        t0 = cyc;
        rd(`OFS_COUNTER);
        v0 = rd_val[7:0];
        while (cyc < t0 + 64) @(posedge clk_sys);
        rd(`OFS_COUNTER);
        chk(nm, {24'h0, exp}, {24'h0, rd_val[7:0] - v0});
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'h0;
        rd(`OFS_GENERAL_CTRL); chk("gen_reset", 32'h00, rd_val);
        rd(`OFS_TIMER_CTRL); chk("tcr_reset", 32'h00, rd_val);
        rd(`OFS_TOP_COMPARE); chk("top_reset", 32'hFF, rd_val);
        rd(8'h50); chk("unmapped_rd", 32'h2, {30'h0, rd_resp});
        wr(8'h50, 32'h1); chk("unmapped_wr", 32'h2, {30'h0, wr_resp});
        $display("test reset_values done");
        // Stored bits read back, strobes read zero, counter kept
        wr(`OFS_COUNTER, 32'h5A);
        wr(`OFS_GENERAL_CTRL, 32'h83);
        rd(`OFS_GENERAL_CTRL); chk("gen_bits", 32'h81, rd_val);
        rd(`OFS_COUNTER); chk("cnt_kept", 32'h5A, rd_val);
        $display("test stored_bits done");
        // Forced actions in normal mode, channel B mode written with its strobe
        wr(`OFS_GENERAL_CTRL, 32'h0);
        wr(`OFS_PIN_CONFIG, 32'h3);
        for (i = 0; i < 5; i++) begin
            m = mtab[i];
            wr(`OFS_TIMER_CTRL, {26'h0, m, 4'h0});
            wr(`OFS_GENERAL_CTRL, {26'h0, m, 4'hC});
            repeat (3) @(posedge clk_sys);
            chk("pin_a", {29'h0, m != 2'h0, 1'h0, vtab[i]},
                {29'h0, compare_out_a_oe, compare_out_a_n_oe, compare_out_a & (m != 2'h0)});
            chk("pin_b", {29'h0, m != 2'h0, 1'h0, vtab[i]},
                {29'h0, compare_out_b_oe, compare_out_b_n_oe, compare_out_b & (m != 2'h0)});
        end
        wr(`OFS_PIN_CONFIG, 32'h0);
        wr(`OFS_TIMER_CTRL, 32'h30);
        wr(`OFS_GENERAL_CTRL, 32'h3C);
        repeat (3) @(posedge clk_sys);
        chk("pin_dir", 32'h0, {30'h0, compare_out_a_oe, compare_out_b_oe});
        $display("test forced_actions done");
        // Divide ratios from the system clock, then from the fast tick
        wr(`OFS_GENERAL_CTRL, 32'h0);
        for (i = 0; i < 5; i++)
            rate("rate_sync", i[7:0], i == 0 ? 8'h0 : 8'h40 >> (i - 1));
        wr(`OFS_PIN_CONFIG, 32'h4);
        rate("rate_async", 8'h1, 8'h20);
        rate("rate_async", 8'h2, 8'h10);
        $display("test clock_select done");
        // Top match returns the counter to zero
        wr(`OFS_PIN_CONFIG, 32'h3);
        wr(`OFS_TOP_COMPARE, 32'h10);
        for (i = 0; i < 3; i++) begin
            wr(`OFS_COUNTER, 32'h0);
            wr(`OFS_TIMER_CTRL, i == 0 ? 32'h81 : i == 1 ? 32'h41 : 32'h01);
            if (i == 2) wr(`OFS_GENERAL_CTRL, 32'h40);
            repeat (8) begin
                rd(`OFS_COUNTER);
                chk("cnt_bound", 32'h1, {31'h0, rd_val <= 32'h10});
            end
        end
        $display("test top_clear done");
        // Output enables per mode in PWM on both channels
        wr(`OFS_COMPARE_A, 32'h8);
        wr(`OFS_COMPARE_B, 32'h8);
        for (i = 0; i < 4; i++) begin
            m = i[1:0];
            wr(`OFS_TIMER_CTRL, {26'h1, m, 4'h1});
            wr(`OFS_GENERAL_CTRL, {26'h1, m, 4'h0});
            repeat (40) @(posedge clk_sys);
            chk("pwm_oe", {28'h0, m != 2'h0, m == 2'h1, m != 2'h0, m == 2'h1},
                {28'h0, compare_out_a_oe, compare_out_a_n_oe, compare_out_b_oe, compare_out_b_n_oe});
            // High cycles of both true outputs over one 17-cycle PWM period
            hi = 0;
            repeat (17) begin
                @(posedge clk_sys);
                hi += compare_out_a + compare_out_b;
            end
            if (m != 2'h0) chk("pwm_duty", m == 2'h3 ? 18 : 16, hi);
        end
        $display("test pwm_outputs done");
        end_sim();
    end
endmodule // timer1_control_bench
